// >>> core/ddu_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module ddu_top import ddu_pkg::*; #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        TIMER_UPDATE_TRIGGER_N,
   input  wire logic        STREAM_CLK,
   input  wire logic        STREAM_DATA,
   input  wire logic        STREAM_FRAME,
   output logic [15:0]      OUTPUT_CHANNEL0_DATA_CODE,
   output logic [15:0]      OUTPUT_CHANNEL1_DATA_CODE,
   output logic [1:0]       DAC_BIPOLAR,
   output logic             DAC_LOAD
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   typedef struct packed {
      ddu_wst_t              wst;
      logic                  awready;
      logic                  wready;
      logic [DDU_IDX_W-1:0]  awidx;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      ddu_mode_t             mode;
      logic                  posted;
      logic [1:0]            bipolar;
      logic [1:0][15:0]      hold;
      logic [1:0][15:0]      code;
      logic [1:0][15:0]      dac;
      logic                  load;
      logic [2:0]            trig;
      logic                  trig_lvl;
   } ddu_top_st_t;

   localparam ddu_top_st_t ST_RST = '{
      wst: DDU_W_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
      mode: DDU_MODE_DIRECT, posted: DDU_POSTED_RST,
      bipolar: DDU_BIPOL_RST, trig: {3{DDU_TRIG_IDLE}},
      trig_lvl: DDU_TRIG_IDLE, default: '0};

   ddu_top_st_t          st_q;
   ddu_top_st_t          st_d;
   logic [1:0]           push;
   logic [1:0]           pop;
   logic [1:0]           fin_rdy;
   logic [1:0]           fo_valid;
   logic [1:0][15:0]     fo_data;
   logic [1:0][LW-1:0]   lvl;
   logic                 use_fifo;
   logic                 is_serial;
   logic                 direct;
   logic                 trig_fall;
   logic                 hit_ch;
   logic                 wr_ch;
   logic [15:0]          wr_val;
   logic                 stall;
   logic                 wr_commit;
   logic                 upd;
   logic                 ser_ch;
   logic [15:0]          ser_val;
   logic [31:0]          rd_word;

   if (LW > DDU_STAT_LVL_W) begin : g_chk
      $error("fifo depth too large for the status level field");
   end

   ddu_word_if #(.W(DDU_DW))    fin[2] ();
   ddu_word_if #(.W(DDU_DW))    fout[2] ();
   ddu_word_if #(.W(DDU_SER_W)) ser ();

   for (genvar g = 0; g < 2; g++) begin : g_ch
      assign fin[g].valid  = push[g];
      assign fin[g].data   = wr_val;
      assign fout[g].ready = pop[g];
      assign fin_rdy[g]    = fin[g].ready;
      assign fo_valid[g]   = fout[g].valid;
      assign fo_data[g]    = fout[g].data;
      ddu_fifo #(.W(DDU_DW), .DEPTH(FIFO_DEPTH)) u_fifo (
         .clk     (CLK),
         .reset_n (RESET_N),
         .wr      (fin[g]),
         .rd      (fout[g]),
         .level   (lvl[g])
      );
   end

   ddu_serial_rx u_ser (
      .clk          (CLK),
      .reset_n      (RESET_N),
      .stream_clk   (STREAM_CLK),
      .stream_data  (STREAM_DATA),
      .stream_frame (STREAM_FRAME),
      .word         (ser)
   );
   // serial words carry no buffer; every word is taken on arrival
   assign ser.ready = 1'b1;
   assign ser_ch    = ser.data[DDU_SER_CH_BIT];
   assign ser_val   = ser.data[15:0];

   function automatic logic [15:0] merge(input logic [15:0] base,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [15:0] r;
      r = base;
      if (be[0]) r[7:0] = wd[7:0];
      if (be[1]) r[15:8] = wd[15:8];
      return r;
   endfunction

   assign use_fifo  = st_q.mode == DDU_MODE_FIFO && st_q.posted;
   assign is_serial = st_q.mode == DDU_MODE_SERIAL;
   assign direct    = !use_fifo && !is_serial;
   assign trig_fall = st_q.trig[2] == st_q.trig[1] && !st_q.trig[2] &&
                      st_q.trig_lvl;
   assign hit_ch    = st_q.awidx == DDU_IDX_CH0 ||
                      st_q.awidx == DDU_IDX_CH1;
   assign wr_ch     = st_q.awidx == DDU_IDX_CH1;
   assign wr_val    = merge(st_q.hold[wr_ch], st_q.wdata, st_q.wstrb);
   // a full fifo holds the write response back, stalling the master
   assign stall     = st_q.wst == DDU_W_EXEC && hit_ch && use_fifo &&
                      !fin_rdy[wr_ch];
   assign wr_commit = st_q.wst == DDU_W_EXEC && !stall;
   assign upd       = trig_fall ||
                      (wr_commit && st_q.awidx == DDU_IDX_UPD);

   always_comb begin
      rd_word = '0;
      case (S_AXI_ARADDR[7:2])
         DDU_IDX_CTRL: begin
            rd_word[DDU_CTRL_MODE_LSB +: 2]  = st_q.mode;
            rd_word[DDU_CTRL_POSTED]         = st_q.posted;
            rd_word[DDU_CTRL_BIPOL_LSB +: 2] = st_q.bipolar;
         end
         DDU_IDX_STAT: begin
            rd_word[DDU_STAT_FULL_LSB +: 2]  = ~fin_rdy;
            rd_word[DDU_STAT_EMPTY_LSB +: 2] = ~fo_valid;
            rd_word[DDU_STAT_TRIG]           = st_q.trig_lvl;
            rd_word[DDU_STAT_LVL0_LSB +: LW] = lvl[0];
            rd_word[DDU_STAT_LVL1_LSB +: LW] = lvl[1];
         end
         DDU_IDX_OUT: rd_word = {st_q.code[1], st_q.code[0]};
         default: rd_word = '0;
      endcase
   end

   always_comb begin
      st_d = st_q;
      push = '0;
      pop  = '0;
      st_d.load = 1'b0;
      st_d.trig = {st_q.trig[1:0], TIMER_UPDATE_TRIGGER_N};
      if (st_q.trig[2] == st_q.trig[1]) st_d.trig_lvl = st_q.trig[2];

      // update first so a write in the same cycle stays held
      if (upd && st_q.posted) begin
         for (int c = 0; c < 2; c++) begin
            if (use_fifo) begin
               if (fo_valid[c]) begin
                  pop[c] = 1'b1;
                  st_d.code[c] = fo_data[c];
                  st_d.load = 1'b1;
               end
            end else begin
               st_d.code[c] = st_q.hold[c];
               st_d.load = 1'b1;
            end
         end
      end

      // host data writes are ignored while the stream owns the outputs
      if (wr_commit && hit_ch && !is_serial) begin
         st_d.hold[wr_ch] = wr_val;
         if (use_fifo) begin
            push[wr_ch] = 1'b1;
         end else if (!st_q.posted) begin
            st_d.code[wr_ch] = wr_val;
            st_d.load = 1'b1;
         end
      end
      if (ser.valid && is_serial) begin
         st_d.hold[ser_ch] = ser_val;
         if (!st_q.posted) begin
            st_d.code[ser_ch] = ser_val;
            st_d.load = 1'b1;
         end
      end
      if (wr_commit && st_q.awidx == DDU_IDX_CTRL && st_q.wstrb[0]) begin
         st_d.mode    = ddu_mode_t'(st_q.wdata[DDU_CTRL_MODE_LSB +: 2]);
         st_d.posted  = st_q.wdata[DDU_CTRL_POSTED];
         st_d.bipolar = st_q.wdata[DDU_CTRL_BIPOL_LSB +: 2];
      end
      // the converter takes offset binary; flipping the msb turns a
      // two's complement code into it with no other arithmetic
      for (int c = 0; c < 2; c++) begin
         st_d.dac[c] = st_d.bipolar[c] ? st_d.code[c] ^ DDU_SIGN_FLIP
                                       : st_d.code[c];
      end

      if (S_AXI_AWVALID && st_q.awready) begin
         st_d.awidx   = S_AXI_AWADDR[7:2];
         st_d.awready = 1'b0;
      end
      if (S_AXI_WVALID && st_q.wready) begin
         st_d.wdata  = S_AXI_WDATA;
         st_d.wstrb  = S_AXI_WSTRB;
         st_d.wready = 1'b0;
      end
      case (st_q.wst)
         DDU_W_IDLE: begin
            if (!st_q.awready && !st_q.wready) st_d.wst = DDU_W_EXEC;
         end
         DDU_W_EXEC: begin
            if (!stall) begin
               st_d.bvalid = 1'b1;
               st_d.bresp  = (hit_ch || st_q.awidx == DDU_IDX_CTRL ||
                              st_q.awidx == DDU_IDX_UPD ||
                              st_q.awidx == DDU_IDX_STAT ||
                              st_q.awidx == DDU_IDX_OUT) ?
                             DDU_RESP_OKAY : DDU_RESP_DECERR;
               st_d.wst    = DDU_W_RESP;
            end
         end
         DDU_W_RESP: begin
            if (S_AXI_BREADY) begin
               st_d.bvalid  = 1'b0;
               st_d.awready = 1'b1;
               st_d.wready  = 1'b1;
               st_d.wst     = DDU_W_IDLE;
            end
         end
         default: st_d.wst = DDU_W_IDLE;
      endcase

      if (S_AXI_ARVALID && st_q.arready) begin
         st_d.arready = 1'b0;
         st_d.rvalid  = 1'b1;
         st_d.rdata   = rd_word;
         case (S_AXI_ARADDR[7:2])
            DDU_IDX_CH0, DDU_IDX_CH1, DDU_IDX_CTRL, DDU_IDX_UPD,
            DDU_IDX_STAT, DDU_IDX_OUT: st_d.rresp = DDU_RESP_OKAY;
            default: st_d.rresp = DDU_RESP_DECERR;
         endcase
      end else if (st_q.rvalid && S_AXI_RREADY) begin
         st_d.rvalid  = 1'b0;
         st_d.arready = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign S_AXI_AWREADY = st_q.awready;
   assign S_AXI_WREADY  = st_q.wready;
   assign S_AXI_BVALID  = st_q.bvalid;
   assign S_AXI_BRESP   = st_q.bresp;
   assign S_AXI_ARREADY = st_q.arready;
   assign S_AXI_RVALID  = st_q.rvalid;
   assign S_AXI_RDATA   = st_q.rdata;
   assign S_AXI_RRESP   = st_q.rresp;
   assign OUTPUT_CHANNEL0_DATA_CODE     = st_q.dac[0];
   assign OUTPUT_CHANNEL1_DATA_CODE     = st_q.dac[1];
   assign DAC_BIPOLAR   = st_q.bipolar;
   assign DAC_LOAD      = st_q.load;

   default clocking ast_cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_pin_fall;
      TIMER_UPDATE_TRIGGER_N [*4] ##1 !TIMER_UPDATE_TRIGGER_N [*3];
   endsequence
   sequence s_ar_taken;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   sequence s_both_held;
      st_q.wst == DDU_W_IDLE && !S_AXI_AWREADY && !S_AXI_WREADY;
   endsequence

   AST_IMM_CH0: assert property (
      wr_commit && st_q.awidx == DDU_IDX_CH0 && direct && !st_q.posted
      |=> DAC_LOAD && st_q.code[0] == $past(wr_val))
      else $error("immediate write did not reach channel 0");
   AST_POSTED_CH1: assert property (
      wr_commit && st_q.awidx == DDU_IDX_CH1 && direct && st_q.posted &&
      !upd |=> $stable(OUTPUT_CHANNEL1_DATA_CODE) && st_q.hold[1] == $past(wr_val))
      else $error("posted write to channel 1 was not held");
   AST_PIN_FALL: assert property (
      s_pin_fall |=> trig_fall)
      else $error("timer trigger fall not detected");
   AST_UPD_BOTH: assert property (
      upd && st_q.posted && direct
      |=> DAC_LOAD && st_q.code == $past(st_q.hold))
      else $error("update did not move both held values");
   AST_FIFO_ONLY: assert property (
      (|push || |pop) |-> use_fifo)
      else $error("fifo used outside fifo posted mode");
   AST_UNIPOLAR: assert property (
      !DAC_BIPOLAR[0] |-> OUTPUT_CHANNEL0_DATA_CODE == st_q.code[0])
      else $error("unipolar code altered");
   AST_BIPOLAR: assert property (
      DAC_BIPOLAR[1] |-> OUTPUT_CHANNEL1_DATA_CODE == {~st_q.code[1][15],
                                       st_q.code[1][14:0]})
      else $error("bipolar code not offset by half scale");
   AST_SERIAL: assert property (
      ser.valid && is_serial && !st_q.posted
      |=> DAC_LOAD && st_q.code[$past(ser_ch)] == $past(ser_val))
      else $error("serial word not applied");
   AST_READ_LAT: assert property (
      s_ar_taken |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer not one cycle after address");
   AST_WRITE_LAT: assert property (
      s_both_held ##0 !use_fifo |=> ##1 S_AXI_BVALID)
      else $error("write response late");
endmodule

// >>> core/ddu_pkg.sv
package ddu_pkg;

   localparam int DDU_DW    = 16;
   localparam int DDU_IDX_W = 6;
   localparam int DDU_SER_W = 17;

   // register indices; byte address is four times the index
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_CH0  = 6'h10;
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_CH1  = 6'h12;
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_CTRL = 6'h14;
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_UPD  = 6'h16;
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_STAT = 6'h18;
   localparam logic [DDU_IDX_W-1:0] DDU_IDX_OUT  = 6'h1a;

   // control register fields
   localparam int DDU_CTRL_MODE_LSB  = 0;
   localparam int DDU_CTRL_POSTED    = 2;
   localparam int DDU_CTRL_BIPOL_LSB = 4;

   // status register fields
   localparam int DDU_STAT_FULL_LSB  = 0;
   localparam int DDU_STAT_EMPTY_LSB = 2;
   localparam int DDU_STAT_TRIG      = 4;
   localparam int DDU_STAT_LVL0_LSB  = 8;
   localparam int DDU_STAT_LVL1_LSB  = 16;
   localparam int DDU_STAT_LVL_W     = 8;

   localparam int DDU_SER_CH_BIT = 16;

   typedef enum logic [1:0] {
      DDU_MODE_DIRECT = 2'h0,
      DDU_MODE_FIFO   = 2'h1,
      DDU_MODE_SERIAL = 2'h3
   } ddu_mode_t;

   typedef enum logic [1:0] {
      DDU_W_IDLE = 2'h0,
      DDU_W_EXEC = 2'h1,
      DDU_W_RESP = 2'h3
   } ddu_wst_t;

   localparam logic [1:0]  DDU_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  DDU_RESP_DECERR = 2'h3;
   localparam logic [15:0] DDU_SIGN_FLIP   = 16'h8000;
   localparam logic        DDU_TRIG_IDLE   = 1'h1;
   localparam logic        DDU_POSTED_RST  = 1'h0;
   localparam logic [1:0]  DDU_BIPOL_RST   = 2'h0;

endpackage

// >>> core/ddu_word_if.sv
`timescale 1ns/1ps
interface ddu_word_if #(
   parameter int W = 16
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> core/ddu_fifo.sv
`timescale 1ns/1ps
module ddu_fifo import ddu_pkg::*; #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   ddu_word_if.snk                     wr,
   ddu_word_if.src                     rd,
   output logic [$clog2(DEPTH):0]      level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } ddu_fifo_st_t;

   ddu_fifo_st_t st_q;
   ddu_fifo_st_t st_d;
   logic         full;
   logic         empty;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two, at least two");
   end

   // msb of the pointers tells a full ring from an empty one
   assign full  = st_q.wp[AW] != st_q.rp[AW] &&
                  st_q.wp[AW-1:0] == st_q.rp[AW-1:0];
   assign empty = st_q.wp == st_q.rp;
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = st_q.mem[st_q.rp[AW-1:0]];
   assign level    = st_q.wp - st_q.rp;

   always_comb begin
      st_d = st_q;
      if (wr.valid && !full) begin
         st_d.mem[st_q.wp[AW-1:0]] = wr.data;
         st_d.wp = st_q.wp + 1'b1;
      end
      if (rd.ready && !empty) begin
         st_d.rp = st_q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// >>> core/ddu_serial_rx.sv
`timescale 1ns/1ps
module ddu_serial_rx import ddu_pkg::*; (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic stream_clk,
   input  wire logic stream_data,
   input  wire logic stream_frame,
   ddu_word_if.src   word
);
   localparam int CW = $clog2(DDU_SER_W);

   typedef struct packed {
      logic [2:0]           s_clk;
      logic [2:0]           s_dat;
      logic [2:0]           s_frm;
      logic                 clk_lvl;
      logic                 dat_lvl;
      logic                 frm_lvl;
      logic [DDU_SER_W-1:0] sh;
      logic [CW-1:0]        cnt;
      logic                 valid;
   } ddu_ser_st_t;

   ddu_ser_st_t st_q;
   ddu_ser_st_t st_d;
   logic        rise;

   // a level counts only once the second and third stage agree
   assign rise = st_q.s_clk[2] == st_q.s_clk[1] && st_q.s_clk[2] &&
                 !st_q.clk_lvl;
   assign word.valid = st_q.valid;
   assign word.data  = st_q.sh;

   always_comb begin
      st_d = st_q;
      st_d.valid = 1'b0;
      st_d.s_clk = {st_q.s_clk[1:0], stream_clk};
      st_d.s_dat = {st_q.s_dat[1:0], stream_data};
      st_d.s_frm = {st_q.s_frm[1:0], stream_frame};
      if (st_q.s_clk[2] == st_q.s_clk[1]) st_d.clk_lvl = st_q.s_clk[2];
      if (st_q.s_dat[2] == st_q.s_dat[1]) st_d.dat_lvl = st_q.s_dat[2];
      if (st_q.s_frm[2] == st_q.s_frm[1]) st_d.frm_lvl = st_q.s_frm[2];
      if (!st_q.frm_lvl) begin
         st_d.cnt = '0;
      end else if (rise) begin
         // channel bit first, then data msb first
         st_d.sh = {st_q.sh[DDU_SER_W-2:0], st_q.dat_lvl};
         if (st_q.cnt == CW'(DDU_SER_W - 1)) begin
            st_d.cnt   = '0;
            st_d.valid = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// >>> bench/ddu_dac_model.sv
`timescale 1ns/1ps
module ddu_dac_model (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic [15:0]        code0,
   input  wire logic [15:0]        code1,
   input  wire logic [1:0]         bipolar,
   input  wire logic               load,
   output logic signed [16:0]      val0,
   output logic signed [16:0]      val1
);
   // level in code steps of the reference; bipolar codes are offset binary
   function automatic logic [16:0] lvl(input logic b, input logic [15:0] c);
      return b ? {~c[15], ~c[15], c[14:0]} : {1'b0, c};
   endfunction

   // both converters latch together, so a shared load moves both at once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         val0 <= '0;
         val1 <= '0;
      end else if (load) begin
         val0 <= lvl(bipolar[0], code0);
         val1 <= lvl(bipolar[1], code1);
      end
   end
endmodule

// >>> bench/tb_dual_dac_write_update.sv
`timescale 1ns/1ps
module tb_dual_dac_write_update import ddu_pkg::*;;
   logic               clk = 1'b0;
   logic               reset_n;
   logic [7:0]         awaddr;
   logic [7:0]         araddr;
   logic               awvalid;
   logic               wvalid;
   logic               bready;
   logic               arvalid;
   logic               rready;
   logic [31:0]        wdata;
   logic [3:0]         wstrb;
   logic               awready;
   logic               wready;
   logic               bvalid;
   logic               arready;
   logic               rvalid;
   logic [1:0]         bresp;
   logic [1:0]         rresp;
   logic [31:0]        rdata;
   logic               trig_n;
   logic               sclk;
   logic               sdata;
   logic               sframe;
   logic [15:0]        code0;
   logic [15:0]        code1;
   logic [1:0]         bip_o;
   logic               load;
   logic signed [16:0] val0;
   logic signed [16:0] val1;
   logic [1:0]         bip;
   logic [1:0]         resp;
   logic [31:0]        rd_v;
   logic [31:0]        stat_e;
   logic [15:0]        d0;
   logic [15:0]        d1;
   logic [15:0]        q0[$];
   int                 n_mismatch;
   int                 total_checks;

   always #2 clk = ~clk;

   ddu_top #(.FIFO_DEPTH(4)) u_ddu_top (
      .CLK(clk), .RESET_N(reset_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .TIMER_UPDATE_TRIGGER_N(trig_n), .STREAM_CLK(sclk),
      .STREAM_DATA(sdata), .STREAM_FRAME(sframe), .OUTPUT_CHANNEL0_DATA_CODE(code0),
      .OUTPUT_CHANNEL1_DATA_CODE(code1), .DAC_BIPOLAR(bip_o), .DAC_LOAD(load));

   ddu_dac_model u_ddu_dac_model (
      .clk(clk), .reset_n(reset_n), .code0(code0), .code1(code1),
      .bipolar(bip_o), .load(load), .val0(val0), .val1(val1));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   function automatic logic [31:0] ev(input logic b, input logic [15:0] d);
      return b ? {{16{d[15]}}, d} : {16'h0, d};
   endfunction

   task automatic chv(input logic [15:0] e0, input logic [15:0] e1);
      chk({{15{val0[16]}}, val0}, ev(bip[0], e0), "ch0 level");
      chk({{15{val1[16]}}, val1}, ev(bip[1], e1), "ch1 level");
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [5:0] idx);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rd_v = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // each phase held four cycles so the three-flop sync sees it
   task automatic ser(input logic ch, input logic [15:0] d);
      logic [16:0] w;
      w = {ch, d};
      sframe <= 1'b1;
      for (int i = 16; i >= 0; i--) begin
         sdata <= w[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sframe <= 1'b0;
      sdata <= ~w[0];
      repeat (8) @(posedge clk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #100us;
      n_mismatch++;
      test_done;
   end

   initial begin
      void'($urandom(32'h92b984e5));
      {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {trig_n, sclk, sdata, sframe} = 4'h8;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bip = 2'h0;
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      wr(DDU_IDX_CH0, {16'h0, d0});
      wr(DDU_IDX_CH1, {d0, d1});
      chv(d0, d1);
      // upper byte only; lower byte keeps the last written value
      wstrb <= 4'h2;
      wr(DDU_IDX_CH0, {16'h0, d1});
      wstrb <= 4'hf;
      d0[15:8] = d1[15:8];
      chv(d0, d1);
      rd(DDU_IDX_OUT);
      chk(rd_v, {d1, d0}, "held codes");
      tend("immediate");
      bip = 2'h2;
      wr(DDU_IDX_CTRL, 32'h20);
      // two's complement extremes 8000 and 7fff; ch0 unipolar, ch1 bipolar
      for (int i = 0; i < 2; i++) begin
         d0 = i ? 16'h7fff : 16'h8000;
         d1 = d0;
         wr(DDU_IDX_CH0, {16'h0, d0});
         wr(DDU_IDX_CH1, {16'h0, d1});
         chv(d0, d1);
      end
      tend("polarity");
      bip = 2'h0;
      wr(DDU_IDX_CTRL, 32'h04);
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      wr(DDU_IDX_CH0, {16'h0, d0});
      wr(DDU_IDX_CH1, {16'h0, d1});
      chv(16'h7fff, 16'h7fff);
      wr(DDU_IDX_UPD, 32'h0);
      chv(d0, d1);
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      wr(DDU_IDX_CH0, {16'h0, d0});
      wr(DDU_IDX_CH1, {16'h0, d1});
      trig_n <= 1'b0;
      repeat (8) @(posedge clk);
      chv(d0, d1);
      trig_n <= 1'b1;
      repeat (4) @(posedge clk);
      tend("posted");
      wr(DDU_IDX_CTRL, 32'h05);
      // four words fill the channel 0 fifo of depth four
      for (int i = 0; i < 4; i++) begin
         q0.push_back(16'($urandom));
         wr(DDU_IDX_CH0, {16'h0, q0[i]});
      end
      chv(d0, d1);
      rd(DDU_IDX_STAT);
      stat_e = 32'h1 << DDU_STAT_FULL_LSB | 32'h2 << DDU_STAT_EMPTY_LSB |
               32'h1 << DDU_STAT_TRIG | 32'h4 << DDU_STAT_LVL0_LSB;
      chk(rd_v, stat_e, "fifo status");
      while (q0.size() > 0) begin
         d0 = q0.pop_front();
         wr(DDU_IDX_UPD, 32'h0);
         chv(d0, d1);
      end
      tend("fifo");
      wr(DDU_IDX_CTRL, 32'h03);
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      ser(1'b0, d0);
      ser(1'b1, d1);
      chv(d0, d1);
      wr(DDU_IDX_CH0, $urandom);
      chv(d0, d1);
      // posted serial: the stream word waits for the update strobe
      wr(DDU_IDX_CTRL, 32'h07);
      q0.push_back(16'($urandom));
      ser(1'b0, q0[0]);
      chv(d0, d1);
      d0 = q0.pop_front();
      wr(DDU_IDX_UPD, 32'h0);
      chv(d0, d1);
      tend("serial");
      wr(6'h00, 32'h1);
      chk({30'h0, resp}, {30'h0, DDU_RESP_DECERR}, "write resp");
      rd(6'h00);
      chk({30'h0, resp}, {30'h0, DDU_RESP_DECERR}, "read resp");
      chk(rd_v, 32'h0, "unmapped read");
      tend("map");
      test_done;
   end
endmodule
